// ==== testbench/lofl_framer_chk.sv ====
// concurrent checks on the framer ports
`timescale 1ns/1ps
`default_nettype none

module lofl_framer_chk
  import lofl_pkg::*;
(
  // clocks and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // link side
  input wire logic sysref_i,
  input wire lofl_bus_t lvds_bus_o,
  input wire logic frame_start_o,
  input wire lofl_aper_t aperture_o
);
  wire logic acc_w;
  wire logic map_w;

  ////////////////////////////////////////
  // access phase and address decode
  assign acc_w = psel_i && penable_i;
  assign map_w = paddr_i inside {CTRL_OFS, FRAME_OFS, APER_OFS, STAT_OFS};

  chk_apb_ready: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    acc_w |-> pready_o) else $error("pready low in access");
  chk_err_unmapped: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    acc_w && !map_w |-> pslverr_o) else $error("no error on unmapped address");
  chk_err_mapped: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    acc_w && map_w |-> !pslverr_o) else $error("error on mapped address");
  chk_aper_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !(acc_w && pwrite_i && paddr_i == APER_OFS) |=> $stable(aperture_o)) else $error("aperture moved");
  chk_rdata_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o)) else $error("read data moved");
  // sysref pin edge to frame start, bounded around the quoted latencies
  chk_sysref_lat: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $rose(sysref_i) |-> ##[44:52] frame_start_o) else $error("frame start late");
  chk_start_pulse: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    frame_start_o |=> !frame_start_o) else $error("frame start too long");
  chk_strobe_one: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    lvds_bus_o.strobe[0] |=> !lvds_bus_o.strobe[0]) else $error("strobe too long");

  cover property (@(posedge link_clk_i) frame_start_o);
  cover property (@(posedge link_clk_i) lvds_bus_o.strobe[1]);
  cover property (@(posedge ref_clk_i) pslverr_o);
endmodule

bind lofl_framer lofl_framer_chk u_chk (.ref_clk_i, .rst_n_i, .link_clk_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .prdata_o, .pready_o, .pslverr_o, .sysref_i, .lvds_bus_o, .frame_start_o, .aperture_o);

`default_nettype wire

// ==== testbench/lofl_rx.sv ====
// capture receiver model: frames on the bus a strobe, times the bus b strobe
`timescale 1ns/1ps
`default_nettype none

module lofl_rx
  import lofl_pkg::*;
(
  // link side
  input wire logic link_clk_i,
  input wire lofl_bus_t bus_i,
  // measured frame period and bus b strobe lag
  output logic [7:0] period_o,
  output logic [7:0] skew_o
);
  logic [7:0] cnt_q;

  ////////////////////////////////////////
  // the word after a strobe opens a frame; bus b strobe lag shows stagger
  always_ff @(posedge link_clk_i) begin
    cnt_q <= bus_i.strobe[0] ? 8'h01 : cnt_q + 8'h01;
    if (bus_i.strobe[0]) begin
      period_o <= cnt_q;
    end
    if (bus_i.strobe[1]) begin
      skew_o <= bus_i.strobe[0] ? 8'h00 : cnt_q;
    end
  end
endmodule

`default_nettype wire

// ==== testbench/test_lvds_output_framer_latency.sv ====
// self-checking bench of the lvds output framer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end

module test_lvds_output_framer_latency;
  import lofl_pkg::*;
  logic ref_clk_i = 0, rst_n_i = 0, link_clk_i = 0, sysref_i = 0;
  logic psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic pready_o, pslverr_o, frame_start_o, frame_half_phase_o, er;
  lofl_samples_t core_samples_i = '0;
  lofl_bus_t lvds_bus_o;
  lofl_aper_t aperture_o;
  logic [7:0] period, skew;
  logic [16:0] ap;
  logic [31:0] rv [4] = '{32'h0, 32'h10, 32'h0, 32'h0};
  int num_errors = 0, n_checks = 0, n, fl;

  ////////////////////////////////////////
  // periods 40 and 48 ns never share a rising edge
  always #20 ref_clk_i = ~ref_clk_i;
  always #24 link_clk_i = ~link_clk_i;

  lofl_framer dut (.ref_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .link_clk_i, .sysref_i, .core_samples_i, .lvds_bus_o, .frame_start_o,
    .frame_half_phase_o, .aperture_o);
  lofl_rx u_rx (.link_clk_i, .bus_i(lvds_bus_o), .period_o(period), .skew_o(skew));

  // random samples; bit 0 of each slot high so the lsb lane is recognisable
  always @(posedge link_clk_i) core_samples_i <= lofl_samples_t'({$urandom(), $urandom()} | 64'h001001001001);

  function automatic int exp_lat(input logic [2:0] m);
    if (!m[0]) return (m[1] && m[2]) ? 48 : 47;
    return m[2] ? (m[1] ? 48 : 47) : 46;
  endfunction

  function automatic logic [7:0] exp_skew(input logic [2:0] m);
    return (m[2] && (m[0] || m[1])) ? 8'h00 : 8'h01;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1;
    // no fixed wait: only the watchdog ends a stuck access
    do begin
      @(posedge ref_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask

  task automatic lwait(input int c);
    repeat (c) @(negedge link_clk_i);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // the whole run is under 100 us; twice that means a hang
  initial begin
    #200000;
    num_errors++;
    stop_test;
  end

  ////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h8bd6));
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1;
    lwait(8);
    for (int i = 0; i < 4; i++) begin
      apb(0, 12'(4 * i), 0);
      `CHK("reset value", rv[i], rd)
    end
    apb(0, 12'h010, 0);
    `CHK("unmapped", 1'b1, er)
    `CHK("unmapped data", 32'h00000000, rd)
    ap = 17'($urandom());
    apb(1, APER_OFS, 32'(ap));
    // the write lands at the access edge; look once it has settled
    @(negedge ref_clk_i);
    `CHK("aperture", ap, aperture_o)
    $display("test registers done");
    // every channel, bus and alignment mode, aperture left set
    for (int m = 0; m < 8; m++) begin
      fl = 4 + $urandom_range(36);
      apb(1, FRAME_OFS, 32'(fl));
      apb(1, CTRL_OFS, 32'(m));
      lwait(6);
      @(posedge link_clk_i);
      sysref_i <= 1;
      // n counts the rising edges after the one that raised sysref
      n = 0;
      @(negedge link_clk_i);
      while (frame_start_o !== 1'b1 && n < 100) begin
        @(negedge link_clk_i);
        n++;
      end
      `CHK("latency", exp_lat(3'(m)), n)
      `CHK("half phase", 1'(m[0] && !m[2]), frame_half_phase_o)
      @(posedge link_clk_i);
      sysref_i <= 0;
      lwait(3 * fl + 4);
      `CHK("period", 8'(fl), period)
      `CHK("skew", exp_skew(3'(m)), skew)
      if (!m[1]) `CHK("bus 3", 12'h000, lvds_bus_o.data[3])
      if (!m[1]) `CHK("bus 3 clock", 1'b0, lvds_bus_o.dclk[3])
      $display("test mode %0d done", m);
    end
    apb(0, STAT_OFS, 0);
    `CHK("sysref seen", 1'b1, rd[0])
    apb(1, STAT_OFS, 32'h00000001);
    apb(0, STAT_OFS, 0);
    `CHK("sysref clear", 1'b0, rd[0])
    // lsb strobe on, then off, in dual two-bus mode
    fl = 8;
    apb(1, FRAME_OFS, 32'(fl));
    apb(1, CTRL_OFS, 32'h8);
    lwait(20);
    `CHK("lsb early", 1'b1, lvds_bus_o.data[1][0])
    lwait(36 + fl);
    for (int i = 0; i < 2 * fl; i++) begin
      lwait(1);
      `CHK("lsb strobe", lvds_bus_o.strobe[1], lvds_bus_o.data[1][0])
    end
    apb(0, STAT_OFS, 0);
    `CHK("lsb active", 1'b1, rd[1])
    apb(1, CTRL_OFS, 32'h0);
    lwait(20);
    `CHK("lsb hold", lvds_bus_o.strobe[1], lvds_bus_o.data[1][0])
    lwait(36 + fl);
    `CHK("lsb data", 1'b1, lvds_bus_o.data[1][0])
    $display("test lsb strobe done");
    stop_test;
  end
endmodule

`default_nettype wire

// ==== verilog/lofl_framer.sv ====
// lvds output framer: apb registers, sysref framing, bus mapping and strobes
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module lofl_framer (
  // register clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // link clock domain: core samples and sysref pin
  input wire logic link_clk_i,
  input wire logic sysref_i,
  input wire lofl_pkg::lofl_samples_t core_samples_i,
  // lvds buses and frame markers
  output lofl_pkg::lofl_bus_t lvds_bus_o,
  output logic frame_start_o,
  output logic frame_half_phase_o,
  // sampling instant adjustment towards the analog front end
  output lofl_pkg::lofl_aper_t aperture_o
);
  import lofl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // register domain

  logic [CTRL_W-1:0] ctrl_q;
  logic [FLEN_W-1:0] flen_q;
  logic [APER_W-1:0] aper_q;
  logic sysref_seen_q;
  logic tgl_d_q;
  logic [31:0] prdata_q;
  logic tgl_sync;
  logic lsb_sync;

  // apb decode
  wire acc = psel_i & penable_i;
  wire setup = psel_i & ~penable_i;
  wire hit_ctrl = (paddr_i == CTRL_OFS);
  wire hit_frame = (paddr_i == FRAME_OFS);
  wire hit_aper = (paddr_i == APER_OFS);
  wire hit_stat = (paddr_i == STAT_OFS);
  wire mapped = hit_ctrl | hit_frame | hit_aper | hit_stat;
  wire wr = acc & pwrite_i & mapped;
  wire sysref_evt = tgl_sync ^ tgl_d_q;
  wire stat_clr = wr & hit_stat & pwdata_i[STAT_SYSREF_BIT];

  // read multiplexer, reserved bits read as zero
  wire [31:0] rd_ctrl = {28'h0000000, ctrl_q};
  wire [31:0] rd_frame = {24'h000000, flen_q};
  wire [31:0] rd_aper = {15'h0000, aper_q};
  wire [31:0] rd_stat = {30'h00000000, lsb_sync, sysref_seen_q};
  wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                       hit_frame ? rd_frame :
                       hit_aper ? rd_aper :
                       hit_stat ? rd_stat : 32'h00000000;

  // writable registers; mode fields are meant to change only while idle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RST;
      flen_q <= FLEN_RST;
      aper_q <= APER_RST;
    end else if (wr) begin
      if (hit_ctrl) ctrl_q <= pwdata_i[CTRL_W-1:0];
      if (hit_frame) flen_q <= pwdata_i[FLEN_W-1:0];
      if (hit_aper) aper_q <= pwdata_i[APER_W-1:0];
    end
  end

  // sticky sysref flag: a new event beats a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tgl_d_q <= 1'b0;
      sysref_seen_q <= 1'b0;
    end else begin
      tgl_d_q <= tgl_sync;
      if (sysref_evt) sysref_seen_q <= 1'b1;
      else if (stat_clr) sysref_seen_q <= 1'b0;
    end
  end

  // read data captured in the setup phase so it stands in the access phase
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) prdata_q <= 32'h00000000;
    else if (setup & ~pwrite_i) prdata_q <= rd_mux;
  end

  assign prdata_o = prdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;
  // aperture settings go straight to the clock path, outside the data pipe
  assign aperture_o = aper_q;

  //////////////////////////////////////////////////////////////////////////////
  // crossings into and out of the link domain

  lofl_cfg_t cfg_src;
  lofl_cfg_t cfg;
  logic lrst_n;
  logic sysref_s;
  logic sref_tgl_q;
  logic lsb_active_q;

  assign cfg_src = {flen_q, ctrl_q[CTRL_LSB_BIT], ctrl_q[CTRL_ALIGN_BIT],
                    ctrl_q[CTRL_FOUR_BIT], ctrl_q[CTRL_SINGLE_BIT]};

  lofl_sync #(.WIDTH(1)) u_rst_sync (
    .clk_i(link_clk_i),
    .async_i(rst_n_i),
    .sync_o(lrst_n)
  );

  // quasi-static settings; a multi-bit change may be seen torn for one edge
  lofl_sync #(.WIDTH($bits(lofl_cfg_t))) u_cfg_sync (
    .clk_i(link_clk_i),
    .async_i(cfg_src),
    .sync_o(cfg)
  );

  lofl_sync #(.WIDTH(1)) u_sysref_sync (
    .clk_i(link_clk_i),
    .async_i(sysref_i),
    .sync_o(sysref_s)
  );

  lofl_sync #(.WIDTH(1)) u_tgl_sync (
    .clk_i(ref_clk_i),
    .async_i(sref_tgl_q),
    .sync_o(tgl_sync)
  );

  lofl_sync #(.WIDTH(1)) u_lsb_sync (
    .clk_i(ref_clk_i),
    .async_i(lsb_active_q),
    .sync_o(lsb_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // link domain: sysref latency and frame counter

  logic sref_d_q;
  logic [7:0] cnt_q;
  logic half_q;
  logic [FLEN_W-1:0] pos_q;
  logic fstart_q;

  // dual two-bus output ignores the alignment setting
  wire dual2 = ~cfg.single_chan & ~cfg.four_bus;
  wire aligned = cfg.align & ~dual2;
  wire sysref_edge = sysref_s & ~sref_d_q;

  // latency by mode, in half periods; odd values round down and set frame_half_phase_o
  wire [7:0] lat_half = (aligned & cfg.four_bus) ? LAT_ALIGN4_HALF :
                        ~cfg.single_chan ? LAT_DUAL_HALF :
                        aligned ? LAT_SINGLE_ALIGN2_HALF :
                        LAT_SINGLE_STAG_HALF;
  wire [7:0] lat_cyc = {1'b0, lat_half[7:1]};
  wire fstart = (cnt_q == 8'h01);
  wire [FLEN_W-1:0] flen_m1 = (cfg.frame_len == 8'h00) ? 8'h00 : cfg.frame_len - 8'h01;
  // a shortened frame length must not leave the position stranded above the wrap point
  wire frame_last = (pos_q >= flen_m1);

  // sysref edge loads the countdown; the synchroniser cycles are paid from it
  always_ff @(posedge link_clk_i) begin
    if (!lrst_n) begin
      sref_d_q <= 1'b0;
      sref_tgl_q <= 1'b0;
      cnt_q <= 8'h00;
      half_q <= 1'b0;
    end else begin
      sref_d_q <= sysref_s;
      if (sysref_edge) begin
        sref_tgl_q <= ~sref_tgl_q;
        cnt_q <= lat_cyc - SYNC_CYC;
        half_q <= lat_half[0];
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // frame position wraps at the frame length and restarts at the sysref frame start
  always_ff @(posedge link_clk_i) begin
    if (!lrst_n) begin
      pos_q <= 8'h00;
      fstart_q <= 1'b0;
    end else begin
      fstart_q <= fstart;
      if (fstart | frame_last) pos_q <= 8'h00;
      else pos_q <= pos_q + 8'h01;
    end
  end

  assign frame_start_o = fstart_q;
  assign frame_half_phase_o = half_q;

  //////////////////////////////////////////////////////////////////////////////
  // link domain: digital latency pipe

  lofl_dl_t dl_q [DL_DEPTH];
  lofl_dl_t dl_tap;

  always_ff @(posedge link_clk_i) begin
    dl_q[0] <= {core_samples_i, cfg.lsb_req};
  end

  // the request rides with the samples, so the lane cannot switch early
  genvar s;
  generate
    for (s = 1; s < DL_DEPTH; s++) begin : g_dl
      always_ff @(posedge link_clk_i) begin
        dl_q[s] <= dl_q[s-1];
      end
    end
  endgenerate

  // aligned modes add one period of digital latency
  assign dl_tap = aligned ? dl_q[DIG_LAT_CYC] : dl_q[DIG_LAT_CYC-1];

  //////////////////////////////////////////////////////////////////////////////
  // link domain: bus mapping, stagger, strobes

  lofl_samples_t hist_d [NUM_BUS];
  logic [NUM_BUS-1:0] hist_stb [NUM_BUS];
  wire lofl_samples_t mapped_w;
  lofl_bus_t bus_q;
  logic dclk_q;

  // only the dual four-bus mode interleaves the two channels across buses
  wire perm = ~cfg.single_chan & cfg.four_bus;
  wire [NUM_BUS-1:0] bus_en = cfg.four_bus ? 4'hf : 4'h3;

  // lsb strobe lane switches only at a frame boundary
  always_ff @(posedge link_clk_i) begin
    if (!lrst_n) lsb_active_q <= 1'b0;
    else if (frame_last) lsb_active_q <= dl_tap.lsb_req;
  end

  genvar b;
  generate
    for (b = 0; b < NUM_BUS; b++) begin : g_bus
      localparam int unsigned SWAP = ((b & 1) << 1) | (b >> 1);
      logic [1:0] tap;
      logic [SAMPLE_W-1:0] word;
      logic stb;

      assign mapped_w[b] = perm ? dl_tap.samples[SWAP] : dl_tap.samples[b];

      // short history so each bus can be launched late
      if (b == 0) begin : g_head
        always_ff @(posedge link_clk_i) begin
          hist_d[b] <= mapped_w;
          hist_stb[b] <= {NUM_BUS{frame_last}};
        end
      end else begin : g_tail
        always_ff @(posedge link_clk_i) begin
          hist_d[b] <= hist_d[b-1];
          hist_stb[b] <= hist_stb[b-1];
        end
      end

      // staggered: bus b lags bus a by b periods; aligned: all as slowest
      assign tap = aligned ? (cfg.four_bus ? 2'd3 : 2'd1) : 2'(b);
      assign stb = hist_stb[tap][b] & bus_en[b];
      assign word = ((b == 1) && lsb_active_q) ? {hist_d[tap][b][SAMPLE_W-1:1], stb}
                                              : hist_d[tap][b];

      always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
          bus_q.data[b] <= '0;
          bus_q.strobe[b] <= 1'b0;
          bus_q.dclk[b] <= 1'b0;
        end else begin
          bus_q.data[b] <= bus_en[b] ? word : '0;
          bus_q.strobe[b] <= stb;
          bus_q.dclk[b] <= bus_en[b] & dclk_q;
        end
      end
    end
  endgenerate

  // ddr data clock: one edge per launched word
  always_ff @(posedge link_clk_i) begin
    if (!lrst_n) dclk_q <= 1'b0;
    else dclk_q <= ~dclk_q;
  end

  assign lvds_bus_o = bus_q;

endmodule

`default_nettype wire

// ==== verilog/lofl_pkg.sv ====
// constants, register map and carrier types of the lvds output framer
package lofl_pkg;

  // bus geometry
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned NUM_BUS = 4;
  localparam int unsigned FLEN_W = 8;

  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] FRAME_OFS = 12'h004;
  localparam logic [11:0] APER_OFS = 12'h008;
  localparam logic [11:0] STAT_OFS = 12'h00c;

  // control register fields
  localparam int unsigned CTRL_SINGLE_BIT = 0;
  localparam int unsigned CTRL_FOUR_BIT = 1;
  localparam int unsigned CTRL_ALIGN_BIT = 2;
  localparam int unsigned CTRL_LSB_BIT = 3;
  localparam int unsigned CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // frame register and aperture register fields
  localparam logic [7:0] FLEN_RST = 8'h10;
  localparam int unsigned APER_FINE_POS = 8;
  localparam int unsigned APER_INV_BIT = 16;
  localparam int unsigned APER_W = 17;
  localparam logic [16:0] APER_RST = 17'h00000;

  // status register fields
  localparam int unsigned STAT_SYSREF_BIT = 0;
  localparam int unsigned STAT_LSB_BIT = 1;

  // sysref to frame start latencies in half clock periods
  localparam logic [7:0] LAT_DUAL_HALF = 8'h5e;
  localparam logic [7:0] LAT_ALIGN4_HALF = 8'h60;
  localparam logic [7:0] LAT_SINGLE_STAG_HALF = 8'h5d;
  localparam logic [7:0] LAT_SINGLE_ALIGN2_HALF = 8'h5e;
  // cycles spent in the sysref synchroniser and edge detector
  localparam logic [7:0] SYNC_CYC = 8'h03;

  // digital sample latency and least lsb strobe switch latency, clock periods
  localparam int unsigned DIG_LAT_CYC = 26;
  localparam int unsigned LSB_MIN_CYC = 26;
  localparam int unsigned DL_DEPTH = DIG_LAT_CYC + 1;

  typedef logic [NUM_BUS-1:0][SAMPLE_W-1:0] lofl_samples_t;

  typedef struct packed {
    logic [NUM_BUS-1:0] dclk;
    logic [NUM_BUS-1:0] strobe;
    lofl_samples_t data;
  } lofl_bus_t;

  typedef struct packed {
    logic clock_invert;
    logic [7:0] fine;
    logic [7:0] coarse;
  } lofl_aper_t;

  typedef struct packed {
    logic [FLEN_W-1:0] frame_len;
    logic lsb_req;
    logic align;
    logic four_bus;
    logic single_chan;
  } lofl_cfg_t;

  typedef struct packed {
    lofl_samples_t samples;
    logic lsb_req;
  } lofl_dl_t;

endpackage

// ==== verilog/lofl_sync.sv ====
// two flip-flop level synchroniser into a destination clock
`timescale 1ns/1ps
`default_nettype none

module lofl_sync #(
  parameter int unsigned WIDTH = 1
) (
  // destination clock
  input wire logic clk_i,
  // source level and synchronised copy
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // no reset: the stages flush within two edges and may carry reset itself
  always_ff @(posedge clk_i) begin
    meta_q <= async_i;
    sync_q <= meta_q;
  end

  assign sync_o = sync_q;

endmodule

`default_nettype wire
